/* File: hw/ptm_requester_time_calc.v */
// Time measurement requester: timestamps, round trip, master time and local clock.
//
// Notes on behaviour
// - Master time at t1' is t2' minus half the round trip.
// - Round trip is (t4 - t1) minus (t3 - t2).
// - Request stamp t1 is local time plus controller and phy transmit latency.
// - Response stamp t4 is local time minus controller and phy receive latency.
// - After the response, load master time into local clock; feed time-sync unit.
// - Flag a negative round trip when responder interval exceeds requester interval.
// - Halving is a one-bit right shift; legacy unsigned mode gives 2^63 offset.
// - Local clock and t1, t1', t4, t4' readable as low and high word pairs.
`timescale 1ns/1ps
`include "ptm_requester_regs.vh"

module ptm_requester_time_calc
(
	// Clock, reset and enable
	input  wire        CLK_IN,
	input  wire        RESET_N_IN,
	input  wire        CLK_EN_IN,
	// Link events, same clock domain
	input  wire        REQ_SENT_IN,
	input  wire        RESP_VALID_IN,
	input  wire [63:0] RESP_T2_IN,
	input  wire [63:0] RESP_T3_IN,
	// Time-sync unit
	output reg  [63:0] PUSH_TIME_OUT,
	output reg         PUSH_LOAD_OUT,
	// AXI4-Lite write
	input  wire [7:0]  S_AXI_AWADDR_IN,
	input  wire        S_AXI_AWVALID_IN,
	output reg         S_AXI_AWREADY_OUT,
	input  wire [31:0] S_AXI_WDATA_IN,
	input  wire [3:0]  S_AXI_WSTRB_IN,
	input  wire        S_AXI_WVALID_IN,
	output reg         S_AXI_WREADY_OUT,
	output reg  [1:0]  S_AXI_BRESP_OUT,
	output reg         S_AXI_BVALID_OUT,
	input  wire        S_AXI_BREADY_IN,
	// AXI4-Lite read
	input  wire [7:0]  S_AXI_ARADDR_IN,
	input  wire        S_AXI_ARVALID_IN,
	output reg         S_AXI_ARREADY_OUT,
	output reg  [31:0] S_AXI_RDATA_OUT,
	output reg  [1:0]  S_AXI_RRESP_OUT,
	output reg         S_AXI_RVALID_OUT,
	input  wire        S_AXI_RREADY_IN
);

	localparam [63:0] STEP_NS   = `CLK_STEP_NS;
	localparam [1:0]  PH_IDLE   = 2'h0;
	localparam [1:0]  PH_TRIP   = 2'h1;
	localparam [1:0]  PH_MASTER = 2'h2;
	localparam [1:0]  PH_LOAD   = 2'h3;
	localparam [1:0]  RESP_OKAY = 2'h0;
	localparam [1:0]  RESP_SLV  = 2'h2;

	// ***************************************************************
	// Helpers
	// ***************************************************************
	// Controller latency sits in bits 15:0, phy latency in bits 31:16.
	function [63:0] lat_sum;
		input [31:0] lat;
		begin
			lat_sum = {48'h0000_0000_0000, lat[15:0]} + {48'h0000_0000_0000, lat[31:16]};
		end
	endfunction

	function [63:0] halve;
		input [63:0] trip;
		input        signed_mode;
		begin
			if (signed_mode)
				halve = {trip[63], trip[63:1]};
			else
				halve = {1'b0, trip[63:1]};
		end
	endfunction

	function [31:0] merge;
		input [31:0] old;
		input [31:0] data;
		input [3:0]  strb;
		integer i;
		begin
			merge = old;
			for (i = 0; i < 4; i = i + 1)
				if (strb[i])
					merge[i*8 +: 8] = data[i*8 +: 8];
		end
	endfunction

	// ***************************************************************
	// State
	// ***************************************************************
	reg [31:0] control;
	reg [31:0] tx_latency;
	reg [31:0] rx_latency;
	reg        negative;
	reg        loaded;
	reg [1:0]  phase;
	reg [63:0] local_clock;
	reg [63:0] req_stamp;
	reg [63:0] req_master;
	reg [63:0] resp_stamp;
	reg [63:0] resp_master;
	reg [63:0] round_trip;
	reg [63:0] t2_held;
	reg [63:0] t3_held;
	reg [31:0] high_shadow;
	reg        aw_held;
	reg        w_held;
	reg [7:0]  aw_addr;
	reg [31:0] w_data;
	reg [3:0]  w_strb;

	wire        signed_mode = control[`CTRL_SIGNED_BIT];
	wire        wr_go       = aw_held && w_held && !S_AXI_BVALID_OUT;
	wire        clr_neg     = wr_go && (aw_addr == `OFS_STATUS) && w_strb[0]
	                          && w_data[`STAT_NEGATIVE_BIT];
	wire [63:0] local_next  = local_clock + STEP_NS;
	wire [63:0] trip_value  = (resp_stamp - req_stamp) - (t3_held - t2_held);

	// ***************************************************************
	// Measurement pipeline and local clock
	// ***************************************************************
	always @(posedge CLK_IN or negedge RESET_N_IN)
	begin
		if (!RESET_N_IN)
		begin
			local_clock   <= 64'h0000_0000_0000_0000;
			req_stamp     <= 64'h0000_0000_0000_0000;
			req_master    <= 64'h0000_0000_0000_0000;
			resp_stamp    <= 64'h0000_0000_0000_0000;
			resp_master   <= 64'h0000_0000_0000_0000;
			round_trip    <= 64'h0000_0000_0000_0000;
			t2_held       <= 64'h0000_0000_0000_0000;
			t3_held       <= 64'h0000_0000_0000_0000;
			phase         <= PH_IDLE;
			negative      <= 1'b0;
			loaded        <= 1'b0;
			PUSH_TIME_OUT <= 64'h0000_0000_0000_0000;
			PUSH_LOAD_OUT <= 1'b0;
		end
		else if (CLK_EN_IN)
		begin
			local_clock   <= local_next;
			PUSH_LOAD_OUT <= 1'b0;
			if (clr_neg)
				negative <= 1'b0;
			case (phase)
				PH_IDLE:
				begin
					if (REQ_SENT_IN)
						req_stamp <= local_clock + lat_sum(tx_latency);
					if (RESP_VALID_IN)
					begin
						resp_stamp <= local_clock - lat_sum(rx_latency);
						t2_held    <= RESP_T2_IN;
						t3_held    <= RESP_T3_IN;
						phase      <= PH_TRIP;
					end
				end
				PH_TRIP:
				begin
					round_trip <= trip_value;
					phase      <= PH_MASTER;
				end
				PH_MASTER:
				begin
					// Sign bit set means the responder interval exceeded ours.
					if (round_trip[63])
						negative <= 1'b1;
					req_master <= t2_held - halve(round_trip, signed_mode);
					phase      <= PH_LOAD;
				end
				PH_LOAD:
				begin
					resp_master   <= req_master + (resp_stamp - req_stamp);
					// Master time plus the time elapsed since t1 keeps the clock current.
					local_clock   <= req_master + (local_next - req_stamp);
					loaded        <= 1'b1;
					PUSH_LOAD_OUT <= 1'b1;
					phase         <= PH_IDLE;
				end
				default:
				begin
					phase <= PH_IDLE;
				end
			endcase
			PUSH_TIME_OUT <= local_clock;
		end
	end

	// ***************************************************************
	// AXI4-Lite write channel
	// ***************************************************************
	always @(posedge CLK_IN or negedge RESET_N_IN)
	begin
		if (!RESET_N_IN)
		begin
			control           <= `CTRL_RESET;
			tx_latency        <= `LATENCY_RESET;
			rx_latency        <= `LATENCY_RESET;
			aw_held           <= 1'b0;
			w_held            <= 1'b0;
			aw_addr           <= 8'h00;
			w_data            <= 32'h0000_0000;
			w_strb            <= 4'h0;
			S_AXI_AWREADY_OUT <= 1'b0;
			S_AXI_WREADY_OUT  <= 1'b0;
			S_AXI_BVALID_OUT  <= 1'b0;
			S_AXI_BRESP_OUT   <= RESP_OKAY;
		end
		else if (CLK_EN_IN)
		begin
			S_AXI_AWREADY_OUT <= !aw_held && !S_AXI_AWREADY_OUT;
			S_AXI_WREADY_OUT  <= !w_held && !S_AXI_WREADY_OUT;
			if (S_AXI_AWVALID_IN && S_AXI_AWREADY_OUT)
			begin
				aw_held           <= 1'b1;
				aw_addr           <= S_AXI_AWADDR_IN;
				S_AXI_AWREADY_OUT <= 1'b0;
			end
			if (S_AXI_WVALID_IN && S_AXI_WREADY_OUT)
			begin
				w_held           <= 1'b1;
				w_data           <= S_AXI_WDATA_IN;
				w_strb           <= S_AXI_WSTRB_IN;
				S_AXI_WREADY_OUT <= 1'b0;
			end
			if (wr_go)
			begin
				aw_held          <= 1'b0;
				w_held           <= 1'b0;
				S_AXI_BVALID_OUT <= 1'b1;
				S_AXI_BRESP_OUT  <= RESP_OKAY;
				case (aw_addr)
					`OFS_CONTROL:    control    <= merge(control, w_data, w_strb);
					`OFS_TX_LATENCY: tx_latency <= merge(tx_latency, w_data, w_strb);
					`OFS_RX_LATENCY: rx_latency <= merge(rx_latency, w_data, w_strb);
					`OFS_STATUS:     S_AXI_BRESP_OUT <= RESP_OKAY;
					default:
					begin
						if (aw_addr > `OFS_ROUND_TRIP_HIGH || aw_addr[1:0] != 2'h0)
							S_AXI_BRESP_OUT <= RESP_SLV;
					end
				endcase
			end
			else if (S_AXI_BVALID_OUT && S_AXI_BREADY_IN)
				S_AXI_BVALID_OUT <= 1'b0;
		end
	end

	// ***************************************************************
	// AXI4-Lite read channel
	// ***************************************************************
	// Reading a low word latches its high word, so a pair reads coherently.
	always @(posedge CLK_IN or negedge RESET_N_IN)
	begin
		if (!RESET_N_IN)
		begin
			high_shadow       <= 32'h0000_0000;
			S_AXI_ARREADY_OUT <= 1'b0;
			S_AXI_RVALID_OUT  <= 1'b0;
			S_AXI_RDATA_OUT   <= 32'h0000_0000;
			S_AXI_RRESP_OUT   <= RESP_OKAY;
		end
		else if (CLK_EN_IN)
		begin
			S_AXI_ARREADY_OUT <= !S_AXI_RVALID_OUT && !S_AXI_ARREADY_OUT
			                     && !S_AXI_ARVALID_IN;
			if (S_AXI_ARVALID_IN && !S_AXI_RVALID_OUT && !S_AXI_ARREADY_OUT)
				S_AXI_ARREADY_OUT <= 1'b1;
			if (S_AXI_ARVALID_IN && S_AXI_ARREADY_OUT)
			begin
				S_AXI_ARREADY_OUT <= 1'b0;
				S_AXI_RVALID_OUT  <= 1'b1;
				S_AXI_RRESP_OUT   <= RESP_OKAY;
				case (S_AXI_ARADDR_IN)
					`OFS_CONTROL:          S_AXI_RDATA_OUT <= control;
					`OFS_TX_LATENCY:       S_AXI_RDATA_OUT <= tx_latency;
					`OFS_RX_LATENCY:       S_AXI_RDATA_OUT <= rx_latency;
					`OFS_STATUS:           S_AXI_RDATA_OUT <= {29'h0000_0000, loaded,
					                                           phase != PH_IDLE, negative};
					`OFS_LOCAL_LOW:
					begin
						S_AXI_RDATA_OUT <= local_clock[31:0];
						high_shadow     <= local_clock[63:32];
					end
					`OFS_REQ_STAMP_LOW:
					begin
						S_AXI_RDATA_OUT <= req_stamp[31:0];
						high_shadow     <= req_stamp[63:32];
					end
					`OFS_REQ_MASTER_LOW:
					begin
						S_AXI_RDATA_OUT <= req_master[31:0];
						high_shadow     <= req_master[63:32];
					end
					`OFS_RESP_STAMP_LOW:
					begin
						S_AXI_RDATA_OUT <= resp_stamp[31:0];
						high_shadow     <= resp_stamp[63:32];
					end
					`OFS_RESP_MASTER_LOW:
					begin
						S_AXI_RDATA_OUT <= resp_master[31:0];
						high_shadow     <= resp_master[63:32];
					end
					`OFS_ROUND_TRIP_LOW:
					begin
						S_AXI_RDATA_OUT <= round_trip[31:0];
						high_shadow     <= round_trip[63:32];
					end
					`OFS_LOCAL_HIGH, `OFS_REQ_STAMP_HIGH, `OFS_REQ_MASTER_HIGH,
					`OFS_RESP_STAMP_HIGH, `OFS_RESP_MASTER_HIGH, `OFS_ROUND_TRIP_HIGH:
						S_AXI_RDATA_OUT <= high_shadow;
					default:
					begin
						S_AXI_RDATA_OUT <= 32'h0000_0000;
						S_AXI_RRESP_OUT <= RESP_SLV;
					end
				endcase
			end
			else if (S_AXI_RVALID_OUT && S_AXI_RREADY_IN)
				S_AXI_RVALID_OUT <= 1'b0;
		end
	end

endmodule // ptm_requester_time_calc

/* File: hw/ptm_requester_regs.vh */
// Register offsets, field positions, reset values and timing for the time calculator.
`ifndef PTM_REQUESTER_REGS_VH
`define PTM_REQUESTER_REGS_VH

// ***************************************************************
// Register byte offsets
// ***************************************************************
`define OFS_CONTROL          8'h00
`define OFS_TX_LATENCY       8'h04
`define OFS_RX_LATENCY       8'h08
`define OFS_STATUS           8'h0C
`define OFS_LOCAL_LOW        8'h10
`define OFS_LOCAL_HIGH       8'h14
`define OFS_REQ_STAMP_LOW    8'h18
`define OFS_REQ_STAMP_HIGH   8'h1C
`define OFS_REQ_MASTER_LOW   8'h20
`define OFS_REQ_MASTER_HIGH  8'h24
`define OFS_RESP_STAMP_LOW   8'h28
`define OFS_RESP_STAMP_HIGH  8'h2C
`define OFS_RESP_MASTER_LOW  8'h30
`define OFS_RESP_MASTER_HIGH 8'h34
`define OFS_ROUND_TRIP_LOW   8'h38
`define OFS_ROUND_TRIP_HIGH  8'h3C

// ***************************************************************
// Field positions and reset values
// ***************************************************************
`define CTRL_SIGNED_BIT      0
`define CTRL_RESET           32'h0000_0001
`define LATENCY_RESET        32'h0000_0000
`define STAT_NEGATIVE_BIT    0
`define STAT_BUSY_BIT        1
`define STAT_LOADED_BIT      2

// ***************************************************************
// Timing
// ***************************************************************
`define CLK_PERIOD_PS        10000
`define PS_PER_NS            1000
`define CLK_STEP_NS          (`CLK_PERIOD_PS / `PS_PER_NS)

`endif

/* File: test/ptm_requester_checks_properties.sv */
// Port checker for the time calculator.
`timescale 1ns/1ps
module ptm_requester_checks
(
	input wire        CLK_IN,
	input wire        RESET_N_IN,
	input wire        CLK_EN_IN,
	input wire        RESP_VALID_IN,
	input wire [63:0] PUSH_TIME_OUT,
	input wire        PUSH_LOAD_OUT,
	input wire        S_AXI_AWVALID_IN,
	input wire        S_AXI_AWREADY_OUT,
	input wire        S_AXI_WVALID_IN,
	input wire        S_AXI_WREADY_OUT,
	input wire        S_AXI_BVALID_OUT,
	input wire        S_AXI_BREADY_IN,
	input wire [7:0]  S_AXI_ARADDR_IN,
	input wire        S_AXI_ARVALID_IN,
	input wire        S_AXI_ARREADY_OUT,
	input wire [31:0] S_AXI_RDATA_OUT,
	input wire [1:0]  S_AXI_RRESP_OUT,
	input wire        S_AXI_RVALID_OUT,
	input wire        S_AXI_RREADY_IN
);
	default clocking cb @(posedge CLK_IN); endclocking
	default disable iff (!RESET_N_IN);
	load_after_resp_a: assert property (PUSH_LOAD_OUT |->
		$past(RESP_VALID_IN, 4) || $past(RESP_VALID_IN, 5)) else $error("reload without response");
	load_pulse_a: assert property (PUSH_LOAD_OUT |=> !PUSH_LOAD_OUT)
		else $error("reload pulse too long");
	clock_step_a: assert property ((!PUSH_LOAD_OUT && !$past(PUSH_LOAD_OUT)
		&& !$past(PUSH_LOAD_OUT, 2) && $past(CLK_EN_IN) && $past(CLK_EN_IN, 2)
		&& $past(RESET_N_IN, 2)) |-> PUSH_TIME_OUT == $past(PUSH_TIME_OUT) + 64'h0000_000A)
		else $error("local clock step wrong");
	rd_latency_a: assert property (S_AXI_ARVALID_IN && S_AXI_ARREADY_OUT |=> S_AXI_RVALID_OUT)
		else $error("read answer late");
	rd_hold_a: assert property (S_AXI_RVALID_OUT && !S_AXI_RREADY_IN |=>
		S_AXI_RVALID_OUT && $stable(S_AXI_RDATA_OUT)) else $error("read answer dropped");
	unmapped_rd_a: assert property (S_AXI_ARVALID_IN && S_AXI_ARREADY_OUT &&
		S_AXI_ARADDR_IN > 8'h3C |=> S_AXI_RRESP_OUT == 2'b10 && S_AXI_RDATA_OUT == 32'h0000_0000)
		else $error("unmapped read accepted");
	wr_resp_a: assert property (S_AXI_AWVALID_IN && S_AXI_AWREADY_OUT && S_AXI_WVALID_IN
		&& S_AXI_WREADY_OUT |-> ##[1:2] S_AXI_BVALID_OUT) else $error("write answer late");
	b_hold_a: assert property (S_AXI_BVALID_OUT && !S_AXI_BREADY_IN |=> S_AXI_BVALID_OUT)
		else $error("write answer dropped");
	ar_cause_a: assert property ($rose(S_AXI_ARREADY_OUT) |-> !$past(S_AXI_RVALID_OUT))
		else $error("read ready while answer pending");
	cover property (PUSH_LOAD_OUT);
	cover property (S_AXI_RVALID_OUT && S_AXI_RRESP_OUT == 2'b10);
	cover property (S_AXI_BVALID_OUT && S_AXI_BREADY_IN);
endmodule // ptm_requester_checks

/* File: test/responder_model.sv */
// Responder port model answering each request after a fixed gap.
`timescale 1ns/1ps
module responder_model
#(
	parameter GAP = 8
)
(
	input  wire        clk,
	input  wire        go,
	input  wire [63:0] t2,
	input  wire [63:0] t3,
	output reg         valid,
	output reg  [63:0] t2_out,
	output reg  [63:0] t3_out
);
	integer n = 0;
	initial
	begin
		valid = 0;
		t2_out = 0;
		t3_out = 0;
	end
	// Stamps carry meaning only with valid, so they toggle in between.
	always @(posedge clk)
	begin
		valid <= (n == 1);
		t2_out <= (n == 1) ? t2 : ~t2_out;
		t3_out <= (n == 1) ? t3 : ~t3_out;
		n <= go ? GAP : (n > 0 ? n - 1 : 0);
	end
endmodule // responder_model

/* File: test/ptm_requester_time_calc_bench.sv */
// Self-checking bench for the time calculator.
`timescale 1ns/1ps
module ptm_requester_time_calc_bench;
	localparam [33:0] ALL = 34'h3_FFFF_FFFF;
	reg         clk = 0, rst_n = 0, req = 0, en = 1;
	reg         awv = 0, wv = 0, br = 0, arv = 0, rr = 0;
	reg  [7:0]  awa = 0, ara = 0;
	reg  [31:0] wd = 0;
	reg  [63:0] pt2 = 0, pt3 = 0, hold;
	wire        resp, pload, awr, wrd, bv, arr, rv;
	wire [63:0] t2, t3, pt;
	wire [1:0]  bresp, rresp;
	wire [31:0] rdata;
	integer     fail_count = 0, compares = 0, seed = 55, i;
	reg  [33:0] m, exp_q[$], msk_q[$];
	initial forever #5 clk = ~clk;
	responder_model #(.GAP(8)) i_resp (.clk(clk), .go(req), .t2(pt2), .t3(pt3),
		.valid(resp), .t2_out(t2), .t3_out(t3));
	ptm_requester_time_calc i_dut (.CLK_IN(clk), .RESET_N_IN(rst_n), .CLK_EN_IN(en),
		.REQ_SENT_IN(req), .RESP_VALID_IN(resp), .RESP_T2_IN(t2), .RESP_T3_IN(t3),
		.PUSH_TIME_OUT(pt), .PUSH_LOAD_OUT(pload), .S_AXI_AWADDR_IN(awa),
		.S_AXI_AWVALID_IN(awv), .S_AXI_AWREADY_OUT(awr), .S_AXI_WDATA_IN(wd),
		.S_AXI_WSTRB_IN(4'hF), .S_AXI_WVALID_IN(wv), .S_AXI_WREADY_OUT(wrd),
		.S_AXI_BRESP_OUT(bresp), .S_AXI_BVALID_OUT(bv), .S_AXI_BREADY_IN(br),
		.S_AXI_ARADDR_IN(ara), .S_AXI_ARVALID_IN(arv), .S_AXI_ARREADY_OUT(arr),
		.S_AXI_RDATA_OUT(rdata), .S_AXI_RRESP_OUT(rresp), .S_AXI_RVALID_OUT(rv),
		.S_AXI_RREADY_IN(rr));
	task chk(input [33:0] seen, input [33:0] exp);
	begin
		compares++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("unexpected bus_answer: expected %h seen %h", exp, seen);
		end
	end
	endtask
	task stop_test;
	begin
		$display("compares %0d fail_count %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	end
	endtask
	// The ready of the answer channel is raised after a random wait of up to three cycles.
	task wr(input [7:0] a, input [31:0] d, input [1:0] r);
		integer w;
	begin
		exp_q.push_back({r, 32'h0000_0000});
		msk_q.push_back(34'h3_0000_0000);
		w = $random(seed) & 3;
		@(posedge clk);
		{awa, wd, awv, wv, br} <= {a, d, 2'b11, w == 0};
		do
		begin
			@(posedge clk);
			if (awr) awv <= 0;
			if (wrd) wv <= 0;
			if (w == 1) br <= 1;
			w = w - 1;
		end
		while (!(bv && br));
		br <= 0;
	end
	endtask
	task rd(input [7:0] a, input [33:0] e, input [33:0] mk);
		integer w;
	begin
		exp_q.push_back(e & mk);
		msk_q.push_back(mk);
		w = $random(seed) & 3;
		@(posedge clk);
		{ara, arv, rr} <= {a, 1'b1, w == 0};
		do
		begin
			@(posedge clk);
			if (arr) arv <= 0;
			if (w == 1) rr <= 1;
			w = w - 1;
		end
		while (!(rv && rr));
		rr <= 0;
	end
	endtask
	// One exchange: request, answer after GAP+1 cycles, then the results are read back.
	// The reloaded clock is t1' plus the time since t1, 140 ns less tx, two cycles after the reload is seen.
	task measure(input sm, input [63:0] turn, input zero_lat);
		reg [63:0] dt, rtt, half, t1p, t1s, t4p, loc, t2v;
		reg [31:0] tx, rx;
	begin
		tx = zero_lat ? 32'h0000_0000 : $random(seed) & 32'h000F_000F;
		rx = zero_lat ? 32'h0000_0000 : $random(seed) & 32'h000F_000F;
		t2v = {$random(seed), $random(seed)} >> 2;
		dt = 64'd90 - tx[15:0] - tx[31:16] - rx[15:0] - rx[31:16];
		rtt = dt - turn;
		half = sm ? {rtt[63], rtt[63:1]} : {1'b0, rtt[63:1]};
		t1p = t2v - half;
		t1s = t2v - {rtt[63], rtt[63:1]};
		t4p = t1p + dt;
		loc = t1p + 64'd140 - tx[15:0] - tx[31:16];
		wr(8'h00, {31'h0, sm}, 2'b00);
		wr(8'h04, tx, 2'b00);
		wr(8'h08, rx, 2'b00);
		@(posedge clk);
		pt2 <= t2v;
		req <= 1;
		@(posedge clk);
		req <= 0;
		pt3 <= t2v + turn;
		for (i = 0; i < 40 && !pload; i++) @(posedge clk);
		repeat (2) @(posedge clk);
		chk(pt[31:0], loc[31:0]);
		chk(pt[61:32], loc[61:32]);
		rd(8'h38, rtt[31:0], ALL);
		rd(8'h3C, rtt[63:32], ALL);
		rd(8'h20, t1p[31:0], ALL);
		rd(8'h24, t1p[63:32], ALL);
		rd(8'h24, t1s[63:32], 34'h0_3FFF_FFFF);
		rd(8'h30, t4p[31:0], ALL);
		rd(8'h0C, rtt[63], 34'h1);
		wr(8'h0C, 32'h0000_0001, 2'b00);
		rd(8'h0C, 34'h0, 34'h1);
	end
	endtask
	always @(posedge clk)
	begin
		if ((bv && br) || (rv && rr))
		begin
			m = msk_q.pop_front();
			chk((bv ? {bresp, 32'h0000_0000} : {rresp, rdata}) & m, exp_q.pop_front());
		end
	end
	initial
	begin
		repeat (10) @(posedge clk);
		rst_n <= 1;
		rd(8'h00, 34'h1, ALL);
		rd(8'h04, 34'h0, ALL);
		rd(8'h08, 34'h0, ALL);
		rd(8'h40, 34'h2_0000_0000, ALL);
		wr(8'h02, 32'h0000_0000, 2'b10);
		measure(1, 64'd4, 0);
		// With the clock enable low the pushed time must not move.
		@(posedge clk);
		en <= 0;
		repeat (2) @(posedge clk);
		hold = pt;
		repeat (4) @(posedge clk);
		chk(pt[33:0], hold[33:0]);
		en <= 1;
		measure(1, 64'd5000, 0);
		measure(0, 64'd5000, 0);
		measure(0, 64'd4, 1);
		stop_test;
	end
	initial
	begin
		#200000;
		fail_count++;
		stop_test;
	end
endmodule // ptm_requester_time_calc_bench
bind ptm_requester_time_calc ptm_requester_checks i_chk (.CLK_IN, .RESET_N_IN, .CLK_EN_IN,
	.RESP_VALID_IN, .PUSH_TIME_OUT, .PUSH_LOAD_OUT, .S_AXI_AWVALID_IN, .S_AXI_AWREADY_OUT,
	.S_AXI_WVALID_IN, .S_AXI_WREADY_OUT, .S_AXI_BVALID_OUT, .S_AXI_BREADY_IN, .S_AXI_ARADDR_IN,
	.S_AXI_ARVALID_IN, .S_AXI_ARREADY_OUT, .S_AXI_RDATA_OUT, .S_AXI_RRESP_OUT,
	.S_AXI_RVALID_OUT, .S_AXI_RREADY_IN);
